// File: dpf_pkg.sv
// Purpose: shared constants for the downstream port forwarding control
// Assumes: configuration offsets are byte offsets into the port's space
// Notes:   bridge control offset is a placement of this design
package dpf_pkg;

  // ==========================================================
  // configuration space map
  localparam logic [7:0]  CAP_ID_OFFSET     = 8'h50;
  localparam logic [7:0]  BRIDGE_CTL_OFFSET = 8'h3e;
  localparam logic [7:0]  CAP_ID_VALUE      = 8'h01;

  // ==========================================================
  // bridge forwarding control fields
  localparam int          BCTL_POISON_BIT   = 0;
  localparam int          BCTL_SERR_BIT     = 1;
  localparam int          BCTL_LEGACY_BIT   = 2;
  localparam logic [2:0]  BCTL_RESET_VALUE  = 3'h0;
  localparam logic [15:0] BCTL_RW_MASK      = 16'h0007;

  // ==========================================================
  // i/o address decode constants
  localparam logic [15:0] IO_HIGH_ZERO      = 16'h0000;
  localparam int          ALIAS_LO_BIT      = 8;
  localparam int          ALIAS_HI_BIT      = 9;
  localparam logic [9:0]  VGA_R1_LO         = 10'h3b0;
  localparam logic [9:0]  VGA_R1_HI         = 10'h3bb;
  localparam logic [9:0]  VGA_R2_LO         = 10'h3c0;
  localparam logic [9:0]  VGA_R2_HI         = 10'h3df;

  // address in the top 768 bytes of its 1 kb block
  function automatic logic alias_upper(input logic [31:0] addr);
    alias_upper = |addr[ALIAS_HI_BIT:ALIAS_LO_BIT];
  endfunction

  // address within the first 64 kb of i/o space
  function automatic logic low_64k(input logic [31:0] addr);
    low_64k = (addr[31:16] == IO_HIGH_ZERO);
  endfunction

endpackage

// File: dpf_io_decode.sv
// Purpose: combinational i/o address classification for one direction
// Assumes: base and limit are full 32-bit inclusive window bounds
// Notes:   vga aliases ignore address bits 15:10
`timescale 1ns/1ps
`default_nettype none
module dpf_io_decode (
  // address and window
  input  wire logic [31:0] addr,
  input  wire logic [31:0] io_base,
  input  wire logic [31:0] io_limit,
  // classification
  output logic             in_window,
  output logic             legacy_alias,
  output logic             vga_hit
);

  // ==========================================================
  // window and alias tests
  logic [9:0] low10;
  assign low10        = addr[9:0];
  assign in_window    = (addr >= io_base) && (addr <= io_limit);
  // alias test only meaningful in the low 64 kb
  assign legacy_alias = in_window && dpf_pkg::low_64k(addr)
                        && dpf_pkg::alias_upper(addr);
  assign vga_hit      = dpf_pkg::low_64k(addr) &&
                        (((low10 >= dpf_pkg::VGA_R1_LO) &&
                          (low10 <= dpf_pkg::VGA_R1_HI)) ||
                         ((low10 >= dpf_pkg::VGA_R2_LO) &&
                          (low10 <= dpf_pkg::VGA_R2_HI)));

endmodule // dpf_io_decode
`default_nettype wire

// File: dpf_forward_ctl.sv
// Purpose: downstream port legacy i/o, system error and poison gating
// Assumes: all inputs are on CORE_CLK; config access is one-cycle strobe
// Notes:   decisions appear one cycle after each request strobe
//
// Behaviour
// - legacy block set: drop downstream i/o in top 768 bytes of 1 kb.
// - blocking applies only inside i/o window and lowest 64 kb.
// - legacy block set: forward upstream i/o in top 768 bytes.
// - legacy block clear: forward all downstream i/o inside the window.
// - system error forwarded only if both enables set and error seen.
// - poisoned tlp responses enabled by bit 0, disabled when clear.
// - capability_identifier at 50h is read-only and always returns 01h.
// - bridge bits: legacy block 2, serr forward 1, poison 0; all rw.
// - vga decode enabled: vga forwarding ignores legacy block enable.
`timescale 1ns/1ps
`default_nettype none
module dpf_forward_ctl (
  // clock and reset
  input  wire logic        CORE_CLK,
  input  wire logic        SRST,
  // configuration access
  input  wire logic [7:0]  CFG_ADDR,
  input  wire logic        CFG_WR,
  input  wire logic [1:0]  CFG_BE,
  input  wire logic [15:0] CFG_WDATA,
  input  wire logic        CFG_RD,
  output logic [15:0]      CFG_RDATA,
  output logic             CFG_RVALID,
  // neighbouring configuration state
  input  wire logic [31:0] IO_BASE,
  input  wire logic [31:0] IO_LIMIT,
  input  wire logic        CMD_SERR_ENABLE,
  input  wire logic        VGA_ENABLE,
  // primary to secondary i/o requests
  input  wire logic        DN_REQ,
  input  wire logic [31:0] DN_ADDR,
  output logic             DN_DONE,
  output logic             DN_FORWARD,
  // secondary to primary i/o requests
  input  wire logic        UP_REQ,
  input  wire logic [31:0] UP_ADDR,
  output logic             UP_DONE,
  output logic             UP_FORWARD,
  // secondary link error events
  input  wire logic        SEC_ERR_FATAL,
  input  wire logic        SEC_ERR_NONFATAL,
  output logic             SYS_ERR_FWD,
  // poisoned tlp events
  input  wire logic        POISON_RX,
  output logic             POISON_RESP,
  // control bit view
  output logic             LEGACY_IO_BLOCK_ENABLE
);

  // ==========================================================
  // bridge forwarding control storage
  logic [2:0] bctl_q;
  logic [2:0] bctl_d;
  logic       bctl_hit;
  logic       legacy_io_block_enable;
  logic       system_error_forward_enable;
  logic       poisoned_tlp_response_enable;

  assign bctl_hit = (CFG_ADDR == dpf_pkg::BRIDGE_CTL_OFFSET);
  assign legacy_io_block_enable       = bctl_q[dpf_pkg::BCTL_LEGACY_BIT];
  assign system_error_forward_enable  = bctl_q[dpf_pkg::BCTL_SERR_BIT];
  assign poisoned_tlp_response_enable = bctl_q[dpf_pkg::BCTL_POISON_BIT];
  assign LEGACY_IO_BLOCK_ENABLE       = legacy_io_block_enable;

  // next value: only the low byte lane carries the three control bits
  always_comb begin
    bctl_d = bctl_q;
    if (CFG_WR && bctl_hit && CFG_BE[0]) begin
      bctl_d = CFG_WDATA[2:0];
    end
  end

  // control register; unused bits are not stored and read zero
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      bctl_q <= dpf_pkg::BCTL_RESET_VALUE;
    end else begin
      bctl_q <= bctl_d;
    end
  end

  // ==========================================================
  // configuration read path
  logic [15:0] rdata_d;
  logic [15:0] rdata_q;
  logic        rvalid_q;

  // capability_identifier is a constant; writes to it are simply ignored
  always_comb begin
    rdata_d = 16'h0000;
    if (CFG_ADDR == dpf_pkg::CAP_ID_OFFSET) begin
      rdata_d = {8'h00, dpf_pkg::CAP_ID_VALUE};
    end else if (bctl_hit) begin
      rdata_d = {13'h0000, bctl_q} & dpf_pkg::BCTL_RW_MASK;
    end
  end

  // read data held until the next read
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      rdata_q <= 16'h0000;
    end else if (CFG_RD) begin
      rdata_q <= rdata_d;
    end
  end

  // read valid is a one-cycle pulse after the strobe
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= CFG_RD;
    end
  end

  assign CFG_RDATA  = rdata_q;
  assign CFG_RVALID = rvalid_q;

  // ==========================================================
  // address classification, one decoder per direction
  logic dn_in_window;
  logic dn_alias;
  logic dn_vga;
  logic up_in_window;
  logic up_alias;
  logic up_vga;

  dpf_io_decode u_dn_decode (
    .addr         (DN_ADDR),
    .io_base      (IO_BASE),
    .io_limit     (IO_LIMIT),
    .in_window    (dn_in_window),
    .legacy_alias (dn_alias),
    .vga_hit      (dn_vga)
  );

  dpf_io_decode u_up_decode (
    .addr         (UP_ADDR),
    .io_base      (IO_BASE),
    .io_limit     (IO_LIMIT),
    .in_window    (up_in_window),
    .legacy_alias (up_alias),
    .vga_hit      (up_vga)
  );

  // ==========================================================
  // forwarding decisions
  logic dn_fwd_d;
  logic up_fwd_d;

  // downstream: vga first, since it must not depend on the block bit
  always_comb begin
    dn_fwd_d = 1'b0;
    if (VGA_ENABLE && dn_vga) begin
      dn_fwd_d = 1'b1;
    end else if (dn_in_window) begin
      if (legacy_io_block_enable && dn_alias) begin
        dn_fwd_d = 1'b0;
      end else begin
        dn_fwd_d = 1'b1;
      end
    end
  end

  // upstream: enabled vga stays down; else outside the window goes up, plus blocked aliases in it
  always_comb begin
    up_fwd_d = 1'b0;
    if (VGA_ENABLE && up_vga) begin
      up_fwd_d = 1'b0;
    end else if (!up_in_window) begin
      up_fwd_d = 1'b1;
    end else if (legacy_io_block_enable && up_alias) begin
      up_fwd_d = 1'b1;
    end
  end

  // downstream verdict registered, paired with a done pulse
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      DN_DONE    <= 1'b0;
      DN_FORWARD <= 1'b0;
    end else begin
      DN_DONE    <= DN_REQ;
      if (DN_REQ) begin
        DN_FORWARD <= dn_fwd_d;
      end
    end
  end

  // upstream verdict registered, paired with a done pulse
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      UP_DONE    <= 1'b0;
      UP_FORWARD <= 1'b0;
    end else begin
      UP_DONE    <= UP_REQ;
      if (UP_REQ) begin
        UP_FORWARD <= up_fwd_d;
      end
    end
  end

  // ==========================================================
  // system error forwarding
  logic sys_err_d;

  // fatal and nonfatal share one upstream event; no counting of either
  assign sys_err_d = system_error_forward_enable && CMD_SERR_ENABLE &&
                     (SEC_ERR_FATAL || SEC_ERR_NONFATAL);

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      SYS_ERR_FWD <= 1'b0;
    end else begin
      SYS_ERR_FWD <= sys_err_d;
    end
  end

  // ==========================================================
  // poisoned tlp response gating
  // an event while disabled is dropped, not held for a later enable
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      POISON_RESP <= 1'b0;
    end else begin
      POISON_RESP <= POISON_RX && poisoned_tlp_response_enable;
    end
  end

endmodule // dpf_forward_ctl
`default_nettype wire

// File: dpf_monitor.sv
// Purpose: port-level checks of forwarding, event and config behaviour
// Assumes: bound to dpf_forward_ctl, single clock domain
// Notes:   window and alias terms recomputed from the ports
`timescale 1ns/1ps
`default_nettype none
module dpf_monitor (
  // clock, reset and config bus
  input wire logic        CORE_CLK,
  input wire logic        SRST,
  input wire logic        CFG_WR,
  input wire logic        CFG_RD,
  input wire logic        CFG_RVALID,
  input wire logic [1:0]  CFG_BE,
  input wire logic [7:0]  CFG_ADDR,
  input wire logic [15:0] CFG_WDATA,
  input wire logic [15:0] CFG_RDATA,
  // requests and decisions
  input wire logic [31:0] IO_BASE,
  input wire logic [31:0] IO_LIMIT,
  input wire logic [31:0] DN_ADDR,
  input wire logic [31:0] UP_ADDR,
  input wire logic        VGA_ENABLE,
  input wire logic        DN_REQ,
  input wire logic        DN_FORWARD,
  input wire logic        UP_REQ,
  input wire logic        UP_FORWARD,
  // events
  input wire logic        CMD_SERR_ENABLE,
  input wire logic        SEC_ERR_FATAL,
  input wire logic        SEC_ERR_NONFATAL,
  input wire logic        SYS_ERR_FWD,
  input wire logic        POISON_RX,
  input wire logic        POISON_RESP,
  input wire logic        LEGACY_IO_BLOCK_ENABLE
);
  // ==========================================================
  // helper decode; vga kept apart so each check has one cause
  logic       dn_win, dn_alias, up_alias, dn_vga, leg;
  logic [9:0] lo;
  assign dn_win = DN_ADDR >= IO_BASE && DN_ADDR <= IO_LIMIT;
  assign dn_alias = dn_win && DN_ADDR[31:16] == 16'h0000 && |DN_ADDR[9:8];
  assign up_alias = UP_ADDR >= IO_BASE && UP_ADDR <= IO_LIMIT &&
                    UP_ADDR[31:16] == 16'h0000 && |UP_ADDR[9:8];
  assign lo = DN_ADDR[9:0];
  assign dn_vga = DN_ADDR[31:16] == 16'h0000 &&
    ((lo >= dpf_pkg::VGA_R1_LO && lo <= dpf_pkg::VGA_R1_HI) ||
     (lo >= dpf_pkg::VGA_R2_LO && lo <= dpf_pkg::VGA_R2_HI));
  assign leg = LEGACY_IO_BLOCK_ENABLE;
  // shadow of the control bits, rebuilt from config writes, so the
  // event gates can be checked without peeking inside the block
  logic [2:0] ctl_q;
  logic       serr_on, poison_on;
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      ctl_q <= dpf_pkg::BCTL_RESET_VALUE;
    end else if (CFG_WR && CFG_BE[0] &&
                 CFG_ADDR == dpf_pkg::BRIDGE_CTL_OFFSET) begin
      ctl_q <= CFG_WDATA[2:0];
    end
  end
  assign serr_on   = ctl_q[dpf_pkg::BCTL_SERR_BIT];
  assign poison_on = ctl_q[dpf_pkg::BCTL_POISON_BIT];
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (SRST);
  // ==========================================================
  // config read of the identifier takes two steps
  sequence s_cap_rd; CFG_RD && CFG_ADDR == dpf_pkg::CAP_ID_OFFSET; endsequence
  sequence s_cap_ans; CFG_RVALID && CFG_RDATA == 16'h0001; endsequence
  a_cap_id_fixed: assert property (s_cap_rd |=> s_cap_ans)
    else $error("identifier read wrong");
  a_ctl_bit_write: assert property (CFG_WR && CFG_BE[0] &&
    CFG_ADDR == dpf_pkg::BRIDGE_CTL_OFFSET |=> leg == $past(CFG_WDATA[2]))
    else $error("block enable bit not written");
  a_dn_alias_block: assert property (DN_REQ && leg &&
    !VGA_ENABLE && dn_alias |=> !DN_FORWARD)
    else $error("aliased request forwarded");
  a_dn_high_pass: assert property (DN_REQ && !VGA_ENABLE && dn_win &&
    DN_ADDR[31:16] != 16'h0000 |=> DN_FORWARD) else $error("high i/o held");
  a_up_alias_fwd: assert property (UP_REQ && leg && !VGA_ENABLE &&
    up_alias |=> UP_FORWARD) else $error("upstream alias not forwarded");
  a_dn_clear_fwd: assert property (DN_REQ && !leg && !VGA_ENABLE &&
    dn_win |=> DN_FORWARD) else $error("window address not forwarded");
  a_serr_gate: assert property (SYS_ERR_FWD |-> $past(serr_on &&
    CMD_SERR_ENABLE && (SEC_ERR_FATAL || SEC_ERR_NONFATAL)))
    else $error("system error without cause");
  a_serr_fwd: assert property (serr_on && CMD_SERR_ENABLE &&
    (SEC_ERR_FATAL || SEC_ERR_NONFATAL) |=> SYS_ERR_FWD)
    else $error("qualified system error not forwarded");
  a_poison_cause: assert property (POISON_RESP |->
    $past(POISON_RX && poison_on)) else $error("poison response while off");
  a_poison_resp: assert property (POISON_RX && poison_on |=>
    POISON_RESP) else $error("poisoned tlp not answered");
  a_vga_indep: assert property (DN_REQ && VGA_ENABLE && dn_vga
    |=> DN_FORWARD) else $error("vga address not forwarded");
endmodule // dpf_monitor
bind dpf_forward_ctl dpf_monitor dpf_monitor_inst (.CORE_CLK, .SRST, .CFG_WR,
  .CFG_RD, .CFG_RVALID, .CFG_BE, .CFG_ADDR, .CFG_WDATA, .CFG_RDATA, .IO_BASE,
  .IO_LIMIT, .DN_ADDR, .UP_ADDR, .VGA_ENABLE, .DN_REQ, .DN_FORWARD, .UP_REQ,
  .UP_FORWARD, .CMD_SERR_ENABLE, .SEC_ERR_FATAL, .SEC_ERR_NONFATAL,
  .SYS_ERR_FWD, .POISON_RX, .POISON_RESP, .LEGACY_IO_BLOCK_ENABLE);
`default_nettype wire

// File: dpf_link_partner.sv
// Purpose: secondary link side: upstream requests and error events
// Assumes: bench raises go after a falling edge for one cycle
// Notes:   kinds 3 up request, 4 fatal, 5 nonfatal, 6 poisoned tlp
`timescale 1ns/1ps
`default_nettype none
module dpf_link_partner (
  // command from the bench
  input  wire logic        go,
  input  wire logic [2:0]  kind,
  input  wire logic [31:0] addr,
  // link side events
  output logic             up_req,
  output logic             err_fatal,
  output logic             err_nonfatal,
  output logic             poison,
  output logic [31:0]      up_addr
);
  // released address shows its inverse so a stale value cannot pass
  assign up_addr = go ? addr : ~addr;
  assign up_req = go && kind == 3'h3;
  assign err_fatal = go && kind == 3'h4;
  assign err_nonfatal = go && kind == 3'h5;
  assign poison = go && kind == 3'h6;
endmodule // dpf_link_partner
`default_nettype wire

// File: testbench.sv
// Purpose: directed bench for the forwarding control block
// Assumes: i/o window 1000h..1ffffh crosses the 64 kb boundary
// Notes:   one idle cycle between operations keeps strobes clean
`timescale 1ns/1ps
`default_nettype none
module testbench;
  // ==========================================================
  // bench signals
  logic        clk, srst, cfg_wr, cfg_rd, dn_req, cmd, vga, p_go, rvalid;
  logic        dn_done, dn_fwd, up_req, up_done, up_fwd, fat, nfat, serr;
  logic        poi, presp, leg;
  logic [1:0]  be;
  logic [2:0]  p_kind;
  logic [7:0]  cfg_addr;
  logic [15:0] wdata, rdata;
  logic [31:0] base, limit, dn_addr, p_addr, up_addr;
  int          error_cnt, checks;
  dpf_link_partner dpf_link_partner_inst (.go(p_go), .kind(p_kind),
    .addr(p_addr), .up_req(up_req), .err_fatal(fat), .err_nonfatal(nfat),
    .poison(poi), .up_addr(up_addr));
  dpf_forward_ctl dpf_forward_ctl_inst (.CORE_CLK(clk), .SRST(srst),
    .CFG_ADDR(cfg_addr), .CFG_WR(cfg_wr), .CFG_BE(be), .CFG_WDATA(wdata),
    .CFG_RD(cfg_rd), .CFG_RDATA(rdata), .CFG_RVALID(rvalid), .IO_BASE(base),
    .IO_LIMIT(limit), .CMD_SERR_ENABLE(cmd), .VGA_ENABLE(vga),
    .DN_REQ(dn_req), .DN_ADDR(dn_addr), .DN_DONE(dn_done),
    .DN_FORWARD(dn_fwd), .UP_REQ(up_req), .UP_ADDR(up_addr),
    .UP_DONE(up_done), .UP_FORWARD(up_fwd), .SEC_ERR_FATAL(fat),
    .SEC_ERR_NONFATAL(nfat), .SYS_ERR_FWD(serr), .POISON_RX(poi),
    .POISON_RESP(presp), .LEGACY_IO_BLOCK_ENABLE(leg));
  // 50 mhz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // ==========================================================
  // one operation: 0 wr, 1 rd, 2 down, 3-6 partner, 7 bit view
  task automatic op(input int k, input logic [31:0] a, input logic [15:0] d);
    logic [16:0] got;
    @(negedge clk);
    cfg_addr = a[7:0];
    dn_addr = a;
    p_addr = a;
    wdata = d;
    p_kind = k[2:0];
    cfg_wr = (k == 0);
    cfg_rd = (k == 1);
    dn_req = (k == 2);
    p_go = (k > 2);
    @(negedge clk);
    got = {1'b1, d};
    case (k)
      1: got = {rvalid, rdata};
      2: got = {dn_done, 15'h0000, dn_fwd};
      3: got = {up_done, 15'h0000, up_fwd};
      4, 5: got[0] = serr;
      6: got[0] = presp;
      7: got[0] = leg;
      default: ;
    endcase
    if (k != 0) begin
      checks++;
      if (got !== {1'b1, d}) begin
        error_cnt++;
        $display("unexpected at %0t: op %0d addr %h got %h", $time, k, a, got);
      end
    end
    {cfg_wr, cfg_rd, dn_req, p_go} = 4'h0;
  endtask
  task automatic give_verdict();
    $display("errors %0d checks %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // ==========================================================
  // main sequence
  initial begin
    {srst, cfg_wr, cfg_rd, dn_req, p_go, cmd, vga} = 7'h40;
    {be, p_kind, cfg_addr, wdata, dn_addr, p_addr} = '0;
    base = 32'h0000_1000;
    limit = 32'h0001_ffff;
    error_cnt = 0;
    checks = 0;
    be = 2'h1;
    repeat (2) @(posedge clk);
    @(negedge clk) srst = 1'b0;
    op(1, 8'h3e, 16'h0000);
    op(7, 0, 16'h0000);
    op(0, 8'h50, 16'hffff);
    op(1, 8'h50, 16'h0001);
    op(1, 8'h40, 16'h0000); // unmapped offset reads zero
    op(2, 32'h1100, 16'h0001);
    op(2, 32'h0500, 16'h0000);
    op(0, 8'h3e, 16'hffff);
    op(1, 8'h3e, 16'h0007);
    op(7, 0, 16'h0001);
    be = 2'h0;
    op(0, 8'h3e, 16'h0000);
    op(1, 8'h3e, 16'h0007);
    be = 2'h1;
    for (int i = 0; i < 4; i++)
      op(2, 32'h1000 + (i << 8), 16'(i == 0));
    op(2, 32'h1_0100, 16'h0001);
    op(3, 32'h1300, 16'h0001);
    op(3, 32'h1000, 16'h0000);
    vga = 1'b1;
    op(2, 32'h13b0, 16'h0001);
    op(2, 32'h03c0, 16'h0001);
    vga = 1'b0;
    cmd = 1'b1;
    for (int k = 4; k < 7; k++) op(k, 0, 16'h0001);
    cmd = 1'b0;
    op(4, 0, 16'h0000);
    cmd = 1'b1;
    op(0, 8'h3e, 16'h0004);
    op(5, 0, 16'h0000);
    op(6, 0, 16'h0000);
    give_verdict();
  end
  // watchdog well beyond the roughly 60 cycles the tests need
  initial begin
    #200000;
    error_cnt++;
    give_verdict();
  end
endmodule // testbench
`default_nettype wire
